// ### hdl/sac_adc_ctrl.sv
// SAR converter control: register file, phase sequencer and SAR loop.
// Assumes a classic Wishbone master and an analog front end whose
// comparator output is settled against the trial code at each tick.
`timescale 1ns/1ps

module sac_adc_ctrl #(
   parameter int ADR_W = 14 // Wishbone address width
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic comp_i,
   output sac_pkg::sac_afe_t afe_o,
   output logic irq_o
);
   import sac_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   generate
      if (ADR_W <= IDX_TOP) begin : g_bad_width
         $error("ADR_W too small for the register map");
      end
   endgenerate

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [6:0] cfg_reg; // Control bits six to zero
   logic busy_reg; // Start / busy flag
   logic [3:0] settle_reg; // Settling periods
   logic [5:0] sample_reg; // Sampling periods
   logic [3:0] presc_reg; // Prescale bits
   logic [9:0] result_reg; // Last completed result
   logic [1:0] low_reg; // Low bits latched on high read
   logic irq_reg; // Completion flag
   logic [9:0] sar_reg; // Live SAR value
   logic [9:0] bit_reg; // One-hot trial bit
   sac_state_t state_reg; // Phase
   logic [5:0] cnt_reg; // Phase period counter
   logic [3:0] div_reg; // Prescaler count
   logic [3:0] conv_reg; // Converter tick count
   logic tick_reg; // Registered tick for the pin
   logic [31:0] dat_reg; // Read data
   logic ack_reg; // Bus acknowledge

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic acc; // Request taken this cycle
   logic wr0; // Write to byte lane zero
   logic rd; // Read taken
   logic [ADR_W-3:0] widx; // Word index
   logic hit_ctrl, hit_raw, hit_hi, hit_lo;
   logic hit_settle, hit_sample, hit_presc, hit_irq;

   assign acc = cyc_i & stb_i & ~ack_reg & ce_i;
   assign wr0 = acc & we_i & sel_i[0];
   assign rd = acc & ~we_i;
   assign widx = adr_i[ADR_W-1:ADR_LSB];
   assign hit_ctrl = widx == (ADR_W-2)'(IDX_CTRL);
   assign hit_raw = widx == (ADR_W-2)'(IDX_RAW);
   assign hit_hi = widx == (ADR_W-2)'(IDX_RES_HI);
   assign hit_lo = widx == (ADR_W-2)'(IDX_RES_LO);
   assign hit_settle = widx == (ADR_W-2)'(IDX_SETTLE);
   assign hit_sample = widx == (ADR_W-2)'(IDX_SAMPLE);
   assign hit_presc = widx == (ADR_W-2)'(IDX_PRESC);
   assign hit_irq = widx == (ADR_W-2)'(IDX_IRQ);

   // ----------------------------------------------------------------
   // Sequencer events
   // ----------------------------------------------------------------
   logic start_req; // Start with enable kept on
   logic abort; // Enable written to zero
   logic irq_clr; // Write one to the flag
   logic [3:0] div_max; // Tick spacing minus one
   logic tick; // Converter clock edge
   logic done; // Final tick, result stored

   // Enable must stay one in the start write; a write that drops it
   // both refuses the start and stops the sequence.
   assign start_req = wr0 & hit_ctrl & dat_i[CTRL_START]
                      & dat_i[CTRL_EN];
   assign abort = wr0 & hit_ctrl & ~dat_i[CTRL_EN];
   assign irq_clr = wr0 & hit_irq & dat_i[IRQ_BIT];

   // Highest set divisor wins; none set runs undivided
   always_comb begin
      casez (presc_reg)
         4'b1???: div_max = DIV_16;
         4'b01??: div_max = DIV_8;
         4'b001?: div_max = DIV_4;
         4'b0001: div_max = DIV_2;
         default: div_max = DIV_1;
      endcase
   end

   assign tick = ce_i & (state_reg == S_CONVERT) & (div_reg == div_max);
   assign done = tick & (conv_reg == CONV_LAST) & ~start_req & ~abort;

   // ----------------------------------------------------------------
   // Phase machine
   // ----------------------------------------------------------------
   // Counts of zero still give one period, so a phase never vanishes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
         cnt_reg <= 6'h00;
      end else if (ce_i) begin
         if (abort) begin
            state_reg <= S_IDLE;
         end else if (start_req) begin
            state_reg <= S_SAMPLE;
            cnt_reg <= sample_reg;
         end else begin
            case (state_reg)
               S_SAMPLE: begin
                  if (cnt_reg <= 6'h01) begin
                     state_reg <= S_SETTLE;
                     cnt_reg <= {2'b00, settle_reg};
                  end else begin
                     cnt_reg <= cnt_reg - 6'h01;
                  end
               end
               S_SETTLE: begin
                  if (cnt_reg <= 6'h01) begin
                     state_reg <= S_CONVERT;
                  end else begin
                     cnt_reg <= cnt_reg - 6'h01;
                  end
               end
               S_CONVERT: begin
                  if (done) begin
                     state_reg <= S_IDLE;
                  end
               end
               default: state_reg <= S_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Converter clock and tick counting
   // ----------------------------------------------------------------
   // Prescaler restarts at conversion entry so tick zero is aligned.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg <= 4'h0;
         conv_reg <= 4'h0;
         tick_reg <= 1'b0;
      end else if (ce_i) begin
         tick_reg <= tick;
         if (state_reg != S_CONVERT) begin
            div_reg <= 4'h0;
            conv_reg <= 4'h0;
         end else if (tick) begin
            div_reg <= 4'h0;
            conv_reg <= conv_reg + 4'h1;
         end else begin
            div_reg <= div_reg + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Successive approximation
   // ----------------------------------------------------------------
   // Ticks 0..9 decide bits 9..0; ticks 10..12 let the value rest.
   // A comparator stuck high or low ends at all ones or all zeros.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sar_reg <= 10'h000;
         bit_reg <= 10'h000;
      end else if (ce_i) begin
         if (start_req) begin
            sar_reg <= 10'h000;
            bit_reg <= 10'h000;
         end else if (state_reg == S_SETTLE && cnt_reg <= 6'h01) begin
            sar_reg <= SAR_MSB;
            bit_reg <= SAR_MSB;
         end else if (tick && conv_reg < SAR_TICKS) begin
            sar_reg <= (comp_i ? sar_reg : (sar_reg & ~bit_reg))
                       | (bit_reg >> 1);
            bit_reg <= bit_reg >> 1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Busy flag
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_reg <= 1'b0;
      end else if (ce_i) begin
         if (start_req) busy_reg <= 1'b1;
         else if (done || abort) busy_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Result store and low-bit latch
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_reg <= 10'h000;
         low_reg <= 2'b00;
      end else if (ce_i) begin
         if (done) result_reg <= sar_reg;
         if (rd && hit_hi) low_reg <= result_reg[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Completion flag
   // ----------------------------------------------------------------
   // A completion in the clearing cycle wins; disabling leaves it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else if (ce_i) begin
         if (done) irq_reg <= 1'b1;
         else if (irq_clr) irq_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Software-written registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= CFG_RST;
         settle_reg <= SETTLE_RST;
         sample_reg <= SAMPLE_RST;
         presc_reg <= PRESC_RST;
      end else if (wr0) begin
         if (hit_ctrl) cfg_reg <= dat_i[6:0];
         if (hit_settle) settle_reg <= dat_i[3:0];
         if (hit_sample) sample_reg <= dat_i[5:0];
         if (hit_presc) presc_reg <= dat_i[3:0];
      end
   end

   // ----------------------------------------------------------------
   // Bus answer: one wait state, unmapped reads return zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_reg <= acc;
         dat_reg <= 32'h0000_0000;
         if (rd) begin
            if (hit_ctrl) dat_reg[7:0] <= {busy_reg, cfg_reg};
            if (hit_raw) dat_reg[7:0] <= sar_reg[9:2];
            if (hit_hi) dat_reg[7:0] <= result_reg[9:2];
            if (hit_lo) dat_reg[7:0] <= {low_reg, 6'b00_0000};
            if (hit_settle) dat_reg[3:0] <= settle_reg;
            if (hit_sample) dat_reg[5:0] <= sample_reg;
            if (hit_presc) dat_reg[3:0] <= presc_reg;
            if (hit_irq) dat_reg[IRQ_BIT] <= irq_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Front-end route, reserved codes fall back to grounded nodes
   // ----------------------------------------------------------------
   logic [3:0] sel_route;
   always_comb begin
      case (cfg_reg[3:0])
         SEL_TEMP, SEL_TEMP_PAD, SEL_CHOP_PAD: sel_route = cfg_reg[3:0];
         default: begin
            sel_route = cfg_reg[3] ? SEL_GROUND : cfg_reg[3:0];
         end
      endcase
   end

   logic [3:0] route_reg; // Registered route code
   logic [1:0] phase_reg; // Sample and hold pins, one cycle behind phase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         route_reg <= 4'h0;
         phase_reg <= 2'b00;
      end else if (ce_i) begin
         route_reg <= sel_route;
         phase_reg <= {state_reg == S_SAMPLE, state_reg == S_SETTLE};
      end
   end

   // Outputs are flop values only
   assign dat_o = dat_reg;
   assign ack_o = ack_reg;
   assign irq_o = irq_reg;
   assign afe_o.enable = cfg_reg[CTRL_EN];
   assign afe_o.level = cfg_reg[CTRL_LEVEL];
   assign afe_o.refbuf = cfg_reg[CTRL_REFBUF];
   assign afe_o.input_select = route_reg;
   assign afe_o.sample = phase_reg[1];
   assign afe_o.hold = phase_reg[0];
   assign afe_o.conv_tick = tick_reg;
   assign afe_o.trial = sar_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [7:0] chk_cyc; // Cycles spent converting
   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg != S_CONVERT) begin
         chk_cyc <= 8'h00;
      end else if (ce_i) begin
         chk_cyc <= chk_cyc + 8'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_start;
      start_req && ce_i;
   endsequence
   sequence s_settle_enter;
      state_reg == S_SETTLE && $past(state_reg) != S_SETTLE;
   endsequence

   AST_START_BUSY: assert property (s_start |=>
      busy_reg && state_reg == S_SAMPLE && sar_reg == 10'h000)
      else $error("start did not restart the sequence");
   AST_ZERO_START: assert property (wr0 && hit_ctrl &&
      !dat_i[CTRL_START] && !busy_reg |=> !busy_reg)
      else $error("writing start zero changed busy");
   AST_DONE: assert property (done |=> irq_reg && !busy_reg
      && result_reg == $past(sar_reg))
      else $error("completion did not store and flag");
   AST_HOLD_RESULT: assert property (!done |=>
      $stable(result_reg))
      else $error("result changed without completion");
   AST_IRQ_KEEP: assert property (irq_reg && !(irq_clr && ce_i)
      |=> irq_reg)
      else $error("pending completion flag lost");
   AST_LOW_LATCH: assert property (rd && hit_hi |=>
      low_reg == $past(result_reg[1:0]) && ack_reg)
      else $error("low bits not latched on high read");
   AST_PHASE_ORDER: assert property (s_settle_enter |->
      $past(state_reg) == S_SAMPLE)
      else $error("settling not preceded by sampling");
   AST_CONV_LEN: assert property (done && $stable(presc_reg) |->
      chk_cyc == ({4'h0, div_max} + 8'h01)
      * {4'h0, CONV_LAST + 4'h1} - 8'h01)
      else $error("conversion length is not thirteen ticks");
   AST_RAW_VIEW: assert property (rd && hit_raw |=>
      dat_o[7:0] == $past(sar_reg[9:2]))
      else $error("raw view does not match SAR");
   AST_BUSY_READ: assert property (rd && hit_ctrl |=>
      dat_o[CTRL_START] == $past(busy_reg))
      else $error("busy bit read wrong");

endmodule : sac_adc_ctrl

// ### common/sac_pkg.sv
// Constants, types and register map for the SAR converter control.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
package sac_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_CTRL = 12'h0F70; // Control
   localparam logic [11:0] IDX_RAW = 12'h0F71; // Live SAR view
   localparam logic [11:0] IDX_RES_HI = 12'h0F72; // Result high byte
   localparam logic [11:0] IDX_RES_LO = 12'h0F73; // Result low bits
   localparam logic [11:0] IDX_SETTLE = 12'h0F74; // Settling periods
   localparam logic [11:0] IDX_SAMPLE = 12'h0F75; // Sampling periods
   localparam logic [11:0] IDX_PRESC = 12'h0F76; // Clock prescale
   localparam logic [11:0] IDX_IRQ = 12'h0F77; // Completion flag
   localparam int ADR_LSB = 2; // Word index starts here
   localparam int IDX_TOP = 13; // Highest decoded address bit

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_START = 7; // Start / busy
   localparam int CTRL_LEVEL = 6; // Internal level choice
   localparam int CTRL_REFBUF = 5; // Reference buffer on
   localparam int CTRL_EN = 4; // Converter enable
   localparam int IRQ_BIT = 0; // Completion flag bit
   localparam logic [6:0] CFG_RST = 7'h00;
   localparam logic [3:0] SETTLE_RST = 4'hF;
   localparam logic [5:0] SAMPLE_RST = 6'h3F;
   localparam logic [3:0] PRESC_RST = 4'h0;

   // ----------------------------------------------------------------
   // Converter figures
   // ----------------------------------------------------------------
   localparam int RES_W = 10; // Result width
   localparam logic [3:0] CONV_LAST = 4'hC; // 13th converter tick
   localparam logic [3:0] SAR_TICKS = 4'hA; // Ticks that decide bits
   localparam logic [9:0] SAR_MSB = 10'h200; // First trial bit
   localparam logic [3:0] SEL_GROUND = 4'h8; // Amplifier nodes grounded
   localparam logic [3:0] SEL_TEMP = 4'h9; // Temperature sensor
   localparam logic [3:0] SEL_TEMP_PAD = 4'hC; // Sensor to pad three
   localparam logic [3:0] SEL_CHOP_PAD = 4'hD; // Chop signal to pad three
   localparam logic [3:0] DIV_16 = 4'hF; // Tick spacing minus one
   localparam logic [3:0] DIV_8 = 4'h7;
   localparam logic [3:0] DIV_4 = 4'h3;
   localparam logic [3:0] DIV_2 = 4'h1;
   localparam logic [3:0] DIV_1 = 4'h0;

   // Measurement phases
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_SAMPLE = 2'b01,
      S_SETTLE = 2'b10,
      S_CONVERT = 2'b11
   } sac_state_t;

   // Signals toward the analog front end
   typedef struct packed {
      logic enable; // Converter enable
      logic level; // Internal level choice
      logic refbuf; // Reference buffer on
      logic [3:0] input_select; // Mux / special route code
      logic sample; // Track input
      logic hold; // Hold and settle
      logic conv_tick; // Converter clock pulse
      logic [9:0] trial; // Current SAR trial value
   } sac_afe_t;

endpackage : sac_pkg

// ### bench/sac_afe_model.sv
// Analog front end model: input mux, sample-and-hold, comparator.
// Assumes the control block samples comp_o at its converter ticks.
`timescale 1ns/1ps

module sac_afe_model
   import sac_pkg::*;
(
   input wire logic clk_i,
   input sac_pkg::sac_afe_t afe_i,
   output logic comp_o
);
   // ----------------------------------------------------------------
   // Levels and held sample
   // ----------------------------------------------------------------
   int lv [16]; // Level per route code, in result codes
   int v; // Level on the chosen route
   int held_reg = 0; // Held sample
   logic junk_reg = 1'b0; // Toggles so a stale value never looks valid

   // Mux: grounded route reads zero, others their level
   always_comb begin
      v = (afe_i.input_select == SEL_GROUND) ? 0
         : lv[afe_i.input_select];
   end

   // Track while sampling, hold otherwise
   always_ff @(posedge clk_i) begin
      if (afe_i.sample) begin
         held_reg <= v;
      end
      junk_reg <= ~junk_reg;
   end

   // Out-of-range levels saturate through the compare itself
   assign comp_o = (!afe_i.enable || afe_i.sample) ? junk_reg :
      (held_reg >= int'(afe_i.trial));
endmodule : sac_afe_model

// ### bench/test_sac_adc_ctrl.sv
// Self-checking bench for the SAR converter control block.
// Assumes sac_pkg and the front end model sac_afe_model.
`timescale 1ns/1ps

module test_sac_adc_ctrl;
   import sac_pkg::*;
   // ----------------------------------------------------------------
   // Signals and bench state
   // ----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1; // Clock enable, dropped once to freeze
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [13:0] adr_i = '0;
   logic [3:0] sel_i = '0;
   logic [31:0] dat_i = '0;
   logic [31:0] dat_o, q;
   logic ack_o, comp_i, irq_o;
   sac_afe_t afe_o;
   int n_mismatch = 0, check_count = 0, cyc_n = 0, t_ack = 0, el;
   int n_tick = 0, n_smp = 0, n_hld = 0; // Front-end pin pulse counts
   int lv [16]; // Bench copy of the input levels
   logic [15:0] lfsr = 16'h0044; // Fixed seed
   logic [9:0] last = '0; // Last completed result
   logic have = 1'b0; // A result exists

   always #25 clk_i = ~clk_i;

   // Cycle count, front-end pulse counts and hang limit
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      n_tick <= n_tick + int'(afe_o.conv_tick);
      n_smp <= n_smp + int'(afe_o.sample);
      n_hld <= n_hld + int'(afe_o.hold);
      if (cyc_n == 40000) begin
         n_mismatch++;
         test_done();
      end
   end

   sac_adc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .comp_i(comp_i), .afe_o(afe_o), .irq_o(irq_o));
   sac_afe_model u_afe (.clk_i(clk_i), .afe_i(afe_o), .comp_o(comp_i));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic int rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return int'(lfsr);
   endfunction : rnd

   task automatic set_lv(input int k, input int x);
      lv[k] = x;
      u_afe.lv[k] = x;
   endtask : set_lv

   // One classic cycle; holds until ack, then releases
   task automatic wb(input logic [11:0] idx, input logic w,
      input logic [7:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0000_00, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o;
      t_ack = cyc_n;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 50) n_mismatch++;
      @(posedge clk_i);
   endtask : wb

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_cnt(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         n_mismatch++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_cnt

   // Edges from the start ack until the flag is seen
   task automatic wait_irq(input int t0, output int e);
      int n;
      n = 0;
      while (irq_o !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      e = cyc_n - t0;
   endtask : wait_irq

   function automatic logic [3:0] route(input logic [3:0] s);
      return (s inside {4'hA, 4'hB, 4'hE, 4'hF}) ? SEL_GROUND : s;
   endfunction : route

   function automatic logic [9:0] expect_res(input logic [3:0] s);
      int x;
      x = (route(s) == SEL_GROUND) ? 0 : lv[route(s)];
      x = (x < 0) ? 0 : ((x > 1023) ? 1023 : x);
      return x[9:0];
   endfunction : expect_res

   // Full conversion with random timing fields and level
   task automatic run(input logic [3:0] s);
      int st, se, pr, x, d, t0, k0, s0, h0;
      logic [7:0] c;
      logic [9:0] r;
      st = rnd();
      se = rnd();
      pr = rnd();
      x = rnd();
      set_lv(s, x % 1200 - 88);
      st = st % 64;
      se = se % 16;
      pr = pr % 16;
      d = pr[3] ? 16 : (pr[2] ? 8 : (pr[1] ? 4 : (pr[0] ? 2 : 1)));
      c = {1'b0, lfsr[1:0], 1'b1, s};
      wb(IDX_SAMPLE, 1'b1, st[7:0]);
      wb(IDX_SETTLE, 1'b1, se[7:0]);
      wb(IDX_PRESC, 1'b1, pr[7:0]);
      wb(IDX_PRESC, 1'b0, 8'h00);
      chk_reg(q, pr);
      wb(IDX_CTRL, 1'b1, c);
      chk_reg({afe_o.level, afe_o.refbuf, afe_o.enable, afe_o.input_select},
         {c[6:4], route(s)});
      // Enable was set by the previous write, the start write keeps it
      k0 = n_tick;
      s0 = n_smp;
      h0 = n_hld;
      wb(IDX_CTRL, 1'b1, c | 8'h80);
      t0 = t_ack;
      wb(IDX_CTRL, 1'b0, 8'h00);
      chk_reg(q, c | 8'h80);
      if (have) begin
         wb(IDX_RES_HI, 1'b0, 8'h00);
         chk_reg(q, last[9:2]);
      end
      wait_irq(t0, el);
      chk_cnt(el, (st > 0 ? st : 1) + (se > 0 ? se : 1)
         + 13 * d);
      wb(IDX_CTRL, 1'b0, 8'h00);
      chk_reg(q, c);
      chk_cnt(n_tick - k0, 13);
      chk_cnt(n_smp - s0, st > 0 ? st : 1);
      chk_cnt(n_hld - h0, se > 0 ? se : 1);
      if (have) begin
         wb(IDX_RES_LO, 1'b0, 8'h00);
         chk_reg(q, {last[1:0], 6'h00});
      end
      r = expect_res(s);
      chk_reg(afe_o.trial, r);
      wb(IDX_RAW, 1'b0, 8'h00);
      chk_reg(q, r[9:2]);
      wb(IDX_RES_HI, 1'b0, 8'h00);
      chk_reg(q, r[9:2]);
      wb(IDX_RES_LO, 1'b0, 8'h00);
      chk_reg(q, {r[1:0], 6'h00});
      wb(IDX_IRQ, 1'b0, 8'h00);
      chk_reg(q, 32'h0000_0001);
      wb(IDX_IRQ, 1'b1, 8'h01);
      chk_reg(irq_o, 1'b0);
      last = r;
      have = 1'b1;
   endtask : run

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset values and an unmapped place
      wb(IDX_CTRL, 1'b0, 8'h00);
      chk_reg(q, 32'h0000_0000);
      wb(IDX_SETTLE, 1'b0, 8'h00);
      chk_reg(q, {28'h0000_000, SETTLE_RST});
      wb(IDX_SAMPLE, 1'b0, 8'h00);
      chk_reg(q, {26'h0000_000, SAMPLE_RST});
      wb(IDX_PRESC, 1'b0, 8'h00);
      chk_reg(q, 32'h0000_0000);
      wb(IDX_RES_LO, 1'b0, 8'h00);
      chk_reg(q & 32'h0000_003F, 32'h0000_0000);
      wb(12'h0F78, 1'b1, 8'hFF);
      wb(12'h0F78, 1'b0, 8'h00);
      chk_reg(q, 32'h0000_0000);
      $display("test reset values done");
      // Every select code, random timing and levels
      for (int i = 0; i < 16; i++) begin
         run(i[3:0]);
      end
      $display("test conversions done");
      // Restart mid-run; a zero start bit must not disturb it
      wb(IDX_SAMPLE, 1'b1, 8'h04);
      wb(IDX_SETTLE, 1'b1, 8'h04);
      wb(IDX_PRESC, 1'b1, 8'h00);
      set_lv(5, 300);
      wb(IDX_CTRL, 1'b1, 8'h15);
      wb(IDX_CTRL, 1'b1, 8'h95);
      wb(IDX_CTRL, 1'b1, 8'h15);
      wb(IDX_CTRL, 1'b0, 8'h00);
      chk_reg(q, 32'h0000_0095);
      set_lv(5, 700);
      wb(IDX_CTRL, 1'b1, 8'h95);
      // Five frozen cycles by the clock enable stretch the whole run
      ce_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      ce_i <= 1'b1;
      wait_irq(t_ack, el);
      chk_cnt(el, 4 + 4 + 13 + 5);
      wb(IDX_RES_HI, 1'b0, 8'h00);
      chk_reg(q, 32'h0000_00AF);
      // Disable with the flag pending
      wb(IDX_CTRL, 1'b1, 8'h05);
      chk_reg(irq_o, 1'b1);
      wb(IDX_IRQ, 1'b0, 8'h00);
      chk_reg(q, 32'h0000_0001);
      $display("test restart and disable done");
      test_done();
   end
endmodule : test_sac_adc_ctrl
